/* File: hw/bdh_handler.sv */
// bdh_handler: descriptor side of the serial engine
// assumes the token decoder and byte mover run on clk_sys
// Operation
// - four-byte descriptors, status first, 64 maximum
// - usable sets 32, 33 or 64 by mode
// - table spans 8 to 256 bytes
// - disabled endpoint descriptors are plain RAM
// - descriptor bytes never cleared by reset
// - status bit 7 marks engine ownership
// - core access never blocked by engine
// - engine writes token id and count back
// - completion clears ownership unless keep is set, except SETUP on stall
// - keep holds descriptor, no fifo, no done
// - address hold stops buffer address increment
// - toggle mismatch acked, not stored, no done
// - SETUP accepted despite toggle mismatch
// - toggle check off ignores expected toggle
// - buffer stall answers STALL, flags, keeps descriptor
// - SETUP on stalled descriptor returns ownership
// - ten-bit count, high bits in status
// - owned status holds last token id
module bdh_handler #(
    parameter int NUM_BD = bdh_pkg::NUM_BD_MAX,
    parameter int AW     = 8
) (
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    rst,
    // core side of the table
    input  wire logic [AW-1:0]           coreAddr,
    input  wire logic                    coreWe,
    input  wire logic [7:0]              coreWdata,
    output logic      [7:0]              coreRdata,
    // endpoint configuration
    input  wire logic [bdh_pkg::NUM_EP-1:0] epInEnable,
    input  wire logic [1:0]              bufMode,
    input  wire logic [bdh_pkg::NUM_EP-1:0] epStallClr,
    output logic      [bdh_pkg::NUM_EP-1:0] epStalled,
    // token request
    input  wire logic                    tokValid,
    output logic                         tokReady,
    input  wire logic [5:0]              tokBd,
    input  wire logic [3:0]              tokEp,
    input  wire logic [3:0]              tokPid,
    input  wire logic                    tokToggle,
    // handshake answer
    output logic                         hsValid,
    output logic      [1:0]              hsCode,
    // data phase
    output logic                         xferActive,
    output logic      [15:0]             xferAddr,
    output logic      [9:0]              xferLimit,
    output logic                         xferStore,
    input  wire logic                    byteStrobe,
    input  wire logic                    xferEnd,
    input  wire logic [9:0]              endCount,
    // events
    output logic                         doneFlag,
    output logic                         fifoPush,
    output logic      [3:0]              fifoEp,
    output logic                         stallIrq
);
    import bdh_pkg::*;

    // ========================================
    // declarations
    bdh_state_t  state_r;
    bdh_state_t  state_nxt;
    logic [2:0]  rdIdx_r;
    logic [2:0]  rdIdx_nxt;
    logic [5:0]  bd_r;
    logic [5:0]  bd_nxt;
    logic [3:0]  ep_r;
    logic [3:0]  ep_nxt;
    logic [3:0]  pid_r;
    logic [3:0]  pid_nxt;
    logic        tog_r;
    logic        tog_nxt;
    logic [7:0]  stat_r;
    logic [7:0]  stat_nxt;
    logic [7:0]  cntLo_r;
    logic [7:0]  cntLo_nxt;
    logic [15:0] ptr_r;
    logic [15:0] ptr_nxt;
    logic        store_r;
    logic        store_nxt;
    logic [9:0]  endCnt_r;
    logic [9:0]  endCnt_nxt;
    logic        hsValid_r;
    logic        hsValid_nxt;
    logic [1:0]  hsCode_r;
    logic [1:0]  hsCode_nxt;
    logic        done_r;
    logic        done_nxt;
    logic        stallIrq_r;
    logic        stallIrq_nxt;
    logic [NUM_EP-1:0] stallSet;
    logic [AW-1:0] engAddr;
    logic        engWe;
    logic [7:0]  engWdata;
    logic [7:0]  engRdata;
    logic [6:0]  setLimit;
    logic        isSetup;
    logic        isIn;
    logic [9:0]  descCount;
    logic        keepOut;

    // ========================================
    // descriptor storage, four bytes per descriptor
    bdh_desc_ram #(
        .DEPTH (NUM_BD * BD_BYTES),
        .AW    (AW)
    ) u_ram (
        .clk_sys   (clk_sys),
        .coreAddr  (coreAddr),
        .coreWe    (coreWe),
        .coreWdata (coreWdata),
        .coreRdata (coreRdata),
        .engAddr   (engAddr),
        .engWe     (engWe),
        .engWdata  (engWdata),
        .engRdata  (engRdata)
    );

    bdh_ep_flags #(
        .N (NUM_EP)
    ) u_stall (
        .clk_sys (clk_sys),
        .rst     (rst),
        .setFlag (stallSet),
        .clrFlag (epStallClr),
        .flags   (epStalled)
    );

    // ========================================
    // decode helpers
    always_comb
    begin
        case (bufMode)
            2'h0:    setLimit = 7'(SETS_MODE0);
            2'h1:    setLimit = 7'(SETS_MODE1);
            default: setLimit = 7'(SETS_OTHER);
        endcase
    end

    assign isSetup   = (pid_r == PID_SETUP);
    assign isIn      = (pid_r == PID_IN);
    // ten-bit count spread over status and count byte
    assign descCount = {stat_r[CNT_HI_MSB:0], cntLo_r};
    // a SETUP on a stalled descriptor hands it back regardless of keep
    assign keepOut   = stat_r[BIT_KEEP] & ~(isSetup & stat_r[BIT_STALL]);

    // ========================================
    // engine port of the table
    always_comb
    begin
        engAddr  = AW'({bd_r, OFS_STATUS});
        engWe    = 1'b0;
        engWdata = 8'h00;
        case (state_r)
            BDH_READ:
                engAddr = AW'({bd_r, rdIdx_r[1:0]});
            BDH_WB_CNT:
            begin
                engAddr  = AW'({bd_r, OFS_CNT_LO});
                engWe    = 1'b1;
                engWdata = endCnt_r[7:0];
            end
            BDH_WB_STAT:
            begin
                engAddr  = AW'({bd_r, OFS_STATUS});
                engWe    = 1'b1;
                // toggle bit 6 kept; token id in 5:2
                engWdata = {keepOut, stat_r[BIT_TOGGLE], pid_r, endCnt_r[9:8]};
            end
            default:
                engWe = 1'b0;
        endcase
    end

    // ========================================
    // sequencer next state
    always_comb
    begin
        state_nxt    = state_r;
        rdIdx_nxt    = rdIdx_r;
        bd_nxt       = bd_r;
        ep_nxt       = ep_r;
        pid_nxt      = pid_r;
        tog_nxt      = tog_r;
        stat_nxt     = stat_r;
        cntLo_nxt    = cntLo_r;
        ptr_nxt      = ptr_r;
        store_nxt    = store_r;
        endCnt_nxt   = endCnt_r;
        hsValid_nxt  = 1'b0;
        hsCode_nxt   = hsCode_r;
        done_nxt     = 1'b0;
        stallIrq_nxt = 1'b0;
        stallSet     = '0;
        case (state_r)
            BDH_IDLE:
            begin
                if (tokValid)
                begin
                    bd_nxt    = tokBd;
                    ep_nxt    = tokEp;
                    pid_nxt   = tokPid;
                    tog_nxt   = tokToggle;
                    rdIdx_nxt = 3'h0;
                    state_nxt = BDH_READ;
                end
            end
            BDH_READ:
            begin
                // read data lags the address by one cycle
                case (rdIdx_r)
                    3'h1:    stat_nxt  = engRdata;
                    3'h2:    cntLo_nxt = engRdata;
                    3'h3:    ptr_nxt[7:0] = engRdata;
                    3'h4:    ptr_nxt[15:8] = engRdata;
                    default: stat_nxt  = stat_r;
                endcase
                rdIdx_nxt = rdIdx_r + 3'h1;
                if (rdIdx_r == RD_LAST)
                    state_nxt = BDH_CHECK;
            end
            BDH_CHECK:
            begin
                hsValid_nxt = 1'b1;
                state_nxt   = BDH_IDLE;
                if ((7'(bd_r) >= setLimit) || !epInEnable[ep_r])
                    hsCode_nxt = HS_NONE;
                else if (!stat_r[BIT_OWN])
                    hsCode_nxt = HS_NAK;
                else if (stat_r[BIT_STALL] && !isSetup)
                begin
                    // descriptor left untouched, stays owned
                    hsCode_nxt   = HS_STALL;
                    stallSet[ep_r] = 1'b1;
                    stallIrq_nxt = 1'b1;
                end
                else
                begin
                    hsValid_nxt = 1'b0;
                    // check only on received data, never on SETUP
                    store_nxt = ~(stat_r[BIT_TCHK] & ~isSetup & ~isIn
                                  & (tog_r != stat_r[BIT_TOGGLE]));
                    state_nxt = BDH_DATA;
                end
            end
            BDH_DATA:
            begin
                if (byteStrobe && !stat_r[BIT_HOLD])
                    ptr_nxt = ptr_r + 16'h0001;
                if (xferEnd)
                begin
                    hsValid_nxt = 1'b1;
                    endCnt_nxt  = endCount;
                    state_nxt   = BDH_IDLE;
                    if (!isIn && (endCount > descCount))
                        hsCode_nxt = HS_NAK; // oversize packet, count untouched
                    else if (!store_r)
                        hsCode_nxt = HS_ACK;
                    else
                    begin
                        hsCode_nxt = HS_ACK;
                        state_nxt  = BDH_WB_CNT;
                    end
                end
            end
            BDH_WB_CNT:
                state_nxt = BDH_WB_STAT;
            BDH_WB_STAT:
            begin
                state_nxt = BDH_IDLE;
                done_nxt  = ~keepOut;
            end
            default:
                state_nxt = BDH_IDLE;
        endcase
    end

    // ========================================
    // sequencer registers
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r    <= BDH_IDLE;
            rdIdx_r    <= 3'h0;
            bd_r       <= 6'h00;
            ep_r       <= 4'h0;
            pid_r      <= 4'h0;
            tog_r      <= 1'b0;
            stat_r     <= 8'h00;
            cntLo_r    <= 8'h00;
            ptr_r      <= 16'h0000;
            store_r    <= 1'b0;
            endCnt_r   <= 10'h000;
            hsValid_r  <= 1'b0;
            hsCode_r   <= HS_NONE;
            done_r     <= 1'b0;
            stallIrq_r <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            rdIdx_r    <= rdIdx_nxt;
            bd_r       <= bd_nxt;
            ep_r       <= ep_nxt;
            pid_r      <= pid_nxt;
            tog_r      <= tog_nxt;
            stat_r     <= stat_nxt;
            cntLo_r    <= cntLo_nxt;
            ptr_r      <= ptr_nxt;
            store_r    <= store_nxt;
            endCnt_r   <= endCnt_nxt;
            hsValid_r  <= hsValid_nxt;
            hsCode_r   <= hsCode_nxt;
            done_r     <= done_nxt;
            stallIrq_r <= stallIrq_nxt;
        end
    end

    // ========================================
    // outputs
    assign tokReady   = (state_r == BDH_IDLE);
    assign hsValid    = hsValid_r;
    assign hsCode     = hsCode_r;
    assign xferActive = (state_r == BDH_DATA);
    assign xferAddr   = ptr_r;
    assign xferLimit  = descCount;
    assign xferStore  = store_r & (state_r == BDH_DATA);
    assign doneFlag   = done_r;
    assign fifoPush   = done_r;
    assign fifoEp     = ep_r;
    assign stallIrq   = stallIrq_r;

endmodule : bdh_handler

/* File: hw/bdh_pkg.sv */
// bdh_pkg: constants, layouts and states of the buffer-descriptor handler
// assumes one clock domain; shared by the handler and its two leaf modules
package bdh_pkg;

    // ========================================
    // table geometry
    localparam int NUM_BD_MAX   = 64;
    localparam int BD_BYTES     = 4;
    localparam int TABLE_MIN    = 8;
    localparam int TABLE_MAX    = 256;
    localparam int NUM_EP       = 16;
    localparam int SETS_MODE0   = 32;
    localparam int SETS_MODE1   = 33;
    localparam int SETS_OTHER   = 64;

    // ========================================
    // byte offsets inside one descriptor
    localparam logic [1:0] OFS_STATUS  = 2'h0;
    localparam logic [1:0] OFS_CNT_LO  = 2'h1;
    localparam logic [1:0] OFS_ADDR_LO = 2'h2;
    localparam logic [1:0] OFS_ADDR_HI = 2'h3;

    // ========================================
    // status byte bit positions
    localparam int BIT_OWN    = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_KEEP   = 5;
    localparam int BIT_HOLD   = 4;
    localparam int BIT_TCHK   = 3;
    localparam int BIT_STALL  = 2;
    localparam int PID_LSB    = 2;
    localparam int CNT_HI_MSB = 1;

    // ========================================
    // token identifiers and handshake codes
    localparam logic [3:0] PID_OUT   = 4'h1;
    localparam logic [3:0] PID_IN    = 4'h9;
    localparam logic [3:0] PID_SETUP = 4'hD;
    localparam logic [1:0] HS_NONE   = 2'h0;
    localparam logic [1:0] HS_ACK    = 2'h1;
    localparam logic [1:0] HS_NAK    = 2'h2;
    localparam logic [1:0] HS_STALL  = 2'h3;

    // ========================================
    // reset values and counts
    localparam logic [2:0] RD_LAST = 3'h4;
    localparam logic       FLAG_RST = 1'b0;

    typedef enum logic [2:0] {
        BDH_IDLE,
        BDH_READ,
        BDH_CHECK,
        BDH_DATA,
        BDH_WB_CNT,
        BDH_WB_STAT
    } bdh_state_t;

endpackage : bdh_pkg

/* File: hw/bdh_desc_ram.sv */
// bdh_desc_ram: dual-port byte memory holding the descriptor table
// assumes both ports on clk_sys; contents never reset
module bdh_desc_ram #(
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    // clock
    input  wire logic          clk_sys,
    // core port
    input  wire logic [AW-1:0] coreAddr,
    input  wire logic          coreWe,
    input  wire logic [7:0]    coreWdata,
    output logic      [7:0]    coreRdata,
    // engine port
    input  wire logic [AW-1:0] engAddr,
    input  wire logic          engWe,
    input  wire logic [7:0]    engWdata,
    output logic      [7:0]    engRdata
);
    import bdh_pkg::*;

    // ========================================
    // storage
    logic [7:0] mem [DEPTH];

    // no reset branch: contents stay undefined until written
    // core port is never held off, even on engine-owned bytes
    // same-cycle clash on one byte: engine write lands last
    always_ff @(posedge clk_sys)
    begin
        if (coreWe)
            mem[coreAddr] <= coreWdata;
        if (engWe)
            mem[engAddr] <= engWdata;
        coreRdata <= mem[coreAddr];
        engRdata  <= mem[engAddr];
    end

endmodule : bdh_desc_ram

/* File: hw/bdh_ep_flags.sv */
// bdh_ep_flags: per-endpoint sticky stalled flags
// assumes set pulses from the handler and clear strobes from firmware logic
module bdh_ep_flags #(
    parameter int N = 16
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         rst,
    // set and clear
    input  wire logic [N-1:0] setFlag,
    input  wire logic [N-1:0] clrFlag,
    // state
    output logic      [N-1:0] flags
);
    import bdh_pkg::*;

    // ========================================
    // one flag per endpoint
    logic [N-1:0] flag_r;
    logic [N-1:0] flag_nxt;

    for (genvar i = 0; i < N; i++)
    begin : g_flag
        // set beats clear so a stall in the clearing cycle is kept
        always_comb
        begin
            flag_nxt[i] = flag_r[i];
            if (clrFlag[i])
                flag_nxt[i] = 1'b0;
            if (setFlag[i])
                flag_nxt[i] = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            flag_r <= {N{FLAG_RST}};
        else
            flag_r <= flag_nxt;
    end

    assign flags = flag_r;

endmodule : bdh_ep_flags

/* File: verif/bdh_handler_asserts.sv */
// bdh_handler_asserts: port-level checker for the descriptor handler
// assumes one clk_sys domain; bound from the bench top
module bdh_handler_asserts
    import bdh_pkg::*;
(
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // token and answer
    input  wire logic        tokValid,
    input  wire logic        tokReady,
    input  wire logic        hsValid,
    input  wire logic [1:0]  hsCode,
    // data phase
    input  wire logic        xferActive,
    input  wire logic [15:0] xferAddr,
    input  wire logic        xferStore,
    input  wire logic        byteStrobe,
    // events
    input  wire logic        doneFlag,
    input  wire logic        fifoPush,
    input  wire logic        stallIrq,
    input  wire logic [15:0] epStalled
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ========================================
    // token answer and data phase
    tok_answer_a: assert property (tokValid && tokReady |-> ##[6:8] (hsValid || xferActive))
        else $error("token not answered in time");
    busy_ready_a: assert property (xferActive |-> !tokReady)
        else $error("token accepted during data phase");
    hs_pulse_a: assert property (hsValid |=> !hsValid)
        else $error("handshake pulse longer than one cycle");
    store_active_a: assert property (xferStore |-> xferActive)
        else $error("store enabled outside data phase");
    addr_still_a: assert property ((xferActive && !byteStrobe) ##1 xferActive |-> $stable(xferAddr))
        else $error("buffer address moved without a byte");
    addr_step_a: assert property ((xferActive && byteStrobe) ##1 xferActive |->
        (xferAddr == $past(xferAddr) + 16'h1) || $stable(xferAddr))
        else $error("buffer address step not zero or one");

    // ========================================
    // completion and stall events
    done_pair_a: assert property (doneFlag == fifoPush)
        else $error("done flag and fifo push disagree");
    done_ack_a: assert property (doneFlag |-> $past(hsValid, 2) && hsCode == HS_ACK)
        else $error("done flag without preceding acknowledge");
    stall_code_a: assert property (stallIrq |-> ##[0:1] (hsCode == HS_STALL))
        else $error("stall interrupt without stall answer");
    stall_flag_a: assert property (stallIrq |-> ##[0:2] (epStalled != 16'h0000))
        else $error("stall interrupt without stalled flag");

    cover property (stallIrq);
    cover property (doneFlag);
    cover property (xferActive && byteStrobe);
endmodule : bdh_handler_asserts

/* File: verif/bdh_mover_model.sv */
// bdh_mover_model: byte mover on the far side of the data phase
// assumes the handler's xferActive level on clk_sys; bench sets count and pace
module bdh_mover_model (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // pace from bench
    input  wire logic [9:0] nBytes,
    input  wire logic [9:0] endVal,
    input  wire logic       slow,
    // data phase
    input  wire logic       xferActive,
    output logic            byteStrobe,
    output logic            xferEnd,
    output logic      [9:0] endCount
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // one data phase per rise of xferActive
    initial
    begin
        byteStrobe = 1'b0;
        xferEnd = 1'b0;
        endCount = 10'h3FF;
        forever
        begin
            @(posedge clk_sys);
            if (xferActive === 1'b1 && rst === 1'b0)
            begin
                for (int i = 0; i < int'(nBytes); i++)
                begin
                    repeat (slow ? 3 : 1) @(posedge clk_sys);
                    byteStrobe <= 1'b1;
                    @(posedge clk_sys);
                    byteStrobe <= 1'b0;
                end
                @(posedge clk_sys);
                xferEnd <= 1'b1;
                endCount <= endVal;
                @(posedge clk_sys);
                xferEnd <= 1'b0;
                // count only valid with the end pulse
                endCount <= ~endVal;
                while (xferActive === 1'b1) @(posedge clk_sys);
            end
        end
    end
endmodule : bdh_mover_model

/* File: verif/tb.sv */
// tb: self-checking bench for the descriptor handler
// assumes bench acts as firmware on the core port and token source
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bdh_pkg::*;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  coreAddr = 8'h00;
    logic        coreWe = 1'b0;
    logic [7:0]  coreWdata = 8'h00;
    logic [7:0]  coreRdata;
    logic [15:0] epInEnable = 16'hFFFF;
    logic [1:0]  bufMode = 2'h2;
    logic [15:0] epStallClr = 16'h0000;
    logic [15:0] epStalled;
    logic        tokValid = 1'b0;
    logic        tokReady;
    logic [5:0]  tokBd = 6'h00;
    logic [3:0]  tokEp = 4'h0;
    logic [3:0]  tokPid = 4'h0;
    logic        tokToggle = 1'b0;
    logic        hsValid;
    logic [1:0]  hsCode;
    logic        xferActive, xferStore, byteStrobe, xferEnd;
    logic [15:0] xferAddr;
    logic [9:0]  xferLimit, endCount;
    logic [9:0]  nBytes = 10'h000;
    logic [9:0]  endVal = 10'h000;
    logic        slow = 1'b0;
    logic        doneFlag, fifoPush, stallIrq;
    logic [3:0]  fifoEp;
    int          errCount = 0;
    int          checks = 0;
    int          doneCnt = 0;
    int          stallCnt = 0;
    int          storeCnt = 0;
    int          storeRef = 0;

    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (doneFlag === 1'b1) doneCnt++;
    always @(posedge clk_sys) if (stallIrq === 1'b1) stallCnt++;
    always @(posedge clk_sys) if (xferStore === 1'b1) storeCnt++;

    bdh_handler dut_u (.clk_sys(clk_sys), .rst(rst), .coreAddr(coreAddr), .coreWe(coreWe),
        .coreWdata(coreWdata), .coreRdata(coreRdata), .epInEnable(epInEnable), .bufMode(bufMode),
        .epStallClr(epStallClr), .epStalled(epStalled), .tokValid(tokValid), .tokReady(tokReady),
        .tokBd(tokBd), .tokEp(tokEp), .tokPid(tokPid), .tokToggle(tokToggle), .hsValid(hsValid),
        .hsCode(hsCode), .xferActive(xferActive), .xferAddr(xferAddr), .xferLimit(xferLimit),
        .xferStore(xferStore), .byteStrobe(byteStrobe), .xferEnd(xferEnd), .endCount(endCount),
        .doneFlag(doneFlag), .fifoPush(fifoPush), .fifoEp(fifoEp), .stallIrq(stallIrq));

    bdh_mover_model mover_u (.clk_sys(clk_sys), .rst(rst), .nBytes(nBytes), .endVal(endVal),
        .slow(slow), .xferActive(xferActive), .byteStrobe(byteStrobe), .xferEnd(xferEnd),
        .endCount(endCount));

    // ========================================
    // closing and compare
    task end_sim;
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim

    task chk(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            errCount++;
            $display("CHECK FAILED at %0t exp %h got %h", $time, e, g);
        end
    endtask : chk

    // ========================================
    // core port and token tasks
    task wr(input logic [7:0] a, input logic [7:0] d);
        coreAddr <= a;
        coreWdata <= d;
        coreWe <= 1'b1;
        @(posedge clk_sys);
        coreWe <= 1'b0;
        @(posedge clk_sys);
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        coreAddr <= a;
        repeat (2) @(posedge clk_sys);
        chk(e, coreRdata);
    endtask : rd

    // status byte goes last so the engine never sees a half-armed entry
    task arm(input logic [5:0] bd, input logic [7:0] st, input logic [7:0] cn);
        wr({bd, OFS_CNT_LO}, cn);
        wr({bd, OFS_ADDR_LO}, 8'h00);
        wr({bd, OFS_ADDR_HI}, 8'h05);
        wr({bd, OFS_STATUS}, st);
    endtask : arm

    task sc(input logic [5:0] bd, input logic [7:0] es, input logic [7:0] ec);
        rd({bd, OFS_STATUS}, es);
        rd({bd, OFS_CNT_LO}, ec);
    endtask : sc

    task tk(input logic [5:0] bd, input logic [3:0] ep, input logic [3:0] pid, input logic tg,
            input logic [9:0] n, input logic [9:0] ev, input logic [1:0] ec);
        int k;
        k = 0;
        tokBd <= bd;
        tokEp <= ep;
        tokPid <= pid;
        tokToggle <= tg;
        nBytes <= n;
        endVal <= ev;
        tokValid <= 1'b1;
        do @(posedge clk_sys); while (tokReady !== 1'b1);
        tokValid <= 1'b0;
        while (hsValid !== 1'b1 && k < 3000)
        begin
            @(posedge clk_sys);
            k++;
        end
        // no answer within the limit counts as a mismatch
        if (k >= 3000)
            errCount++;
        chk({6'h00, ec}, {6'h00, hsCode});
        // count and status write-back and done pulse land within four cycles
        repeat (4) @(posedge clk_sys);
    endtask : tk

    // ========================================
    // tests
    logic [1:0] mds [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
    logic [5:0] bds [5] = '{6'h20, 6'h20, 6'h21, 6'h3F, 6'h30};
    logic [1:0] cds [5] = '{HS_NONE, HS_NAK, HS_NONE, HS_NAK, HS_NAK};

    initial
    begin
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        epInEnable <= 16'hFFDF;
        arm(6'h0A, 8'h80, 8'h01);
        tk(6'h0A, 4'h5, PID_OUT, 1'b0, 10'h001, 10'h001, HS_NONE);
        sc(6'h0A, 8'h80, 8'h01);
        epInEnable <= 16'hFFFF;
        $display("test disabled_ep done");
        arm(6'h02, 8'hC1, 8'h05);
        // toggle differs from bit 6 but checking is off, so data is kept
        tk(6'h02, 4'h1, PID_OUT, 1'b0, 10'h005, 10'h105, HS_ACK);
        chk(8'h05, xferAddr[7:0]);
        chk(8'h05, xferLimit[7:0]);
        chk(8'h01, 8'(xferLimit[9:8]));
        chk(8'h01, 8'(fifoEp));
        sc(6'h02, {2'b01, PID_OUT, 2'b01}, 8'h05);
        chk(8'h01, 8'(doneCnt));
        $display("test out_ack done");
        slow <= 1'b1;
        arm(6'h03, 8'hB0, 8'h03);
        tk(6'h03, 4'h1, PID_IN, 1'b0, 10'h003, 10'h003, HS_ACK);
        chk(8'h00, xferAddr[7:0]);
        sc(6'h03, {2'b10, PID_IN, 2'b00}, 8'h03);
        chk(8'h01, 8'(doneCnt));
        slow <= 1'b0;
        $display("test in_keep done");
        arm(6'h04, 8'h88, 8'h08);
        storeRef = storeCnt;
        tk(6'h04, 4'h2, PID_OUT, 1'b1, 10'h002, 10'h002, HS_ACK);
        chk(8'(storeRef), 8'(storeCnt));
        sc(6'h04, 8'h88, 8'h08);
        chk(8'h01, 8'(doneCnt));
        tk(6'h04, 4'h2, PID_SETUP, 1'b1, 10'h008, 10'h008, HS_ACK);
        sc(6'h04, {2'b00, PID_SETUP, 2'b00}, 8'h08);
        chk(8'h02, 8'(doneCnt));
        $display("test toggle done");
        arm(6'h06, 8'h84, 8'h04);
        tk(6'h06, 4'h3, PID_OUT, 1'b0, 10'h004, 10'h004, HS_STALL);
        sc(6'h06, 8'h84, 8'h04);
        chk(8'h08, epStalled[7:0]);
        chk(8'h01, 8'(stallCnt));
        epStallClr <= 16'h0008;
        @(posedge clk_sys);
        epStallClr <= 16'h0000;
        @(posedge clk_sys);
        chk(8'h00, epStalled[7:0]);
        tk(6'h06, 4'h3, PID_SETUP, 1'b0, 10'h004, 10'h004, HS_ACK);
        sc(6'h06, {2'b00, PID_SETUP, 2'b00}, 8'h04);
        tk(6'h06, 4'h3, PID_OUT, 1'b0, 10'h001, 10'h001, HS_NAK);
        $display("test stall done");
        arm(6'h07, 8'h80, 8'h02);
        tk(6'h07, 4'h1, PID_OUT, 1'b0, 10'h003, 10'h003, HS_NAK);
        sc(6'h07, 8'h80, 8'h02);
        $display("test oversize done");
        for (int i = 0; i < 5; i++)
        begin
            bufMode <= mds[i];
            // status cleared so the entry is not owned; the core may write it armed or not
            wr({bds[i], OFS_STATUS}, 8'h00);
            tk(bds[i], 4'h2, PID_OUT, 1'b0, 10'h001, 10'h001, cds[i]);
        end
        $display("test sets done");
        end_sim;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        errCount++;
        end_sim;
    end
endmodule : tb

bind bdh_handler bdh_handler_asserts chk_u (.clk_sys(clk_sys), .rst(rst), .tokValid(tokValid),
    .tokReady(tokReady), .hsValid(hsValid), .hsCode(hsCode), .xferActive(xferActive),
    .xferAddr(xferAddr), .xferStore(xferStore), .byteStrobe(byteStrobe), .doneFlag(doneFlag),
    .fifoPush(fifoPush), .stallIrq(stallIrq), .epStalled(epStalled));
